// ==== hw/gio_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gio_params.svh"

module gio_port
    import gio_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // special-function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata_q,
    // configuration memory port
    input  wire logic [15:0] cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_wdata,
    output logic      [7:0]  cfg_rdata_q,
    // pin configuration levels
    input  wire logic [4:0]  segment_pin_count,
    input  wire logic        energy_pulse_enable,
    input  wire logic        reactive_pulse_enable,
    input  wire logic        eeprom_select,
    input  wire logic        optical_uart_use,
    // compute engine pulses
    input  wire logic        ce_energy_pulse,
    input  wire logic        ce_reactive_pulse,
    // eeprom engine
    input  wire logic        ee_clk_out,
    input  wire logic        ee_clk_oe,
    input  wire logic        ee_data_out,
    input  wire logic        ee_data_oe,
    output logic             ee_data_in_q,
    // optical uart
    input  wire logic        optical_uart_tx,
    output logic             optical_uart_rx_q,
    // pads
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic      [15:0] pin_seg_q,
    // internal resources
    output logic             counter0_clock_in_q,
    output logic             counter1_clock_in_q,
    output logic             high_priority_ext_irq_q,
    output logic             low_priority_ext_irq_q
);

    // segment ownership is needed by pad muxing, readback and routing
    function automatic logic is_seg(input int unsigned idx, input logic [4:0] cnt);
        is_seg = (idx >= `GIO_FIRST_SEG_PIN) && ((idx - `GIO_FIRST_SEG_PIN) < 32'(cnt));
    endfunction : is_seg

    // register state
    logic [7:0]  p1_data_q, p1_data_d, p1_dir_q, p1_dir_d;
    logic [7:0]  p2_data_q, p2_data_d, p2_dir_q, p2_dir_d;
    logic [2:0]  rsel_q [`GIO_NUM_RSEL];
    logic [2:0]  rsel_d [`GIO_NUM_RSEL];
    logic [7:0]  sfr_rdata_d, cfg_rdata_d;
    logic [15:0] data_all, dir_all, seg_now, rd_all;
    logic [15:0] pin_out_d, pin_oe_d, pin_prev_q;
    logic [15:0] cfg_off;
    logic [3:0]  cfg_idx;
    logic        cfg_hit;
    gio_req_t    req     [`GIO_NUM_RSEL];
    gio_req_t    req_any;

    assign data_all = {p2_data_q, p1_data_q};
    assign dir_all  = {p2_dir_q, p1_dir_q};
    assign cfg_off  = cfg_addr - `GIO_CFG_RSEL_FIRST;
    assign cfg_idx  = cfg_off[3:0];
    assign cfg_hit  = (cfg_addr >= `GIO_CFG_RSEL_FIRST) && (cfg_addr <= `GIO_CFG_RSEL_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < `GIO_NUM_PINS; gi++) begin : g_pin
            assign seg_now[gi] = is_seg(gi, segment_pin_count);
            // output pins read back their data register value, not the pad level
            assign rd_all[gi]  = seg_now[gi] ? 1'b0 : (dir_all[gi] ? data_all[gi] : pin_in[gi]);
        end
        for (gi = 0; gi < `GIO_NUM_RSEL; gi++) begin : g_route
            // level taken from the pad so driven pulses are seen too
            gio_res_route u_route (
                .sel    (rsel_q[gi]),
                .lvl    (pin_in[gi]),
                .prev   (pin_prev_q[gi]),
                .usable (!seg_now[gi]),
                .req    (req[gi])
            );
        end
    endgenerate

    always_comb begin
        req_any = 4'h0;
        for (int k = 0; k < `GIO_NUM_RSEL; k++) begin
            req_any = req_any | req[k];
        end
    end

    // register writes and reads
    always_comb begin
        p1_data_d   = p1_data_q;
        p1_dir_d    = p1_dir_q;
        p2_data_d   = p2_data_q;
        p2_dir_d    = p2_dir_q;
        rsel_d      = rsel_q;
        sfr_rdata_d = sfr_rdata_q;
        cfg_rdata_d = cfg_rdata_q;
        if (sfr_wr) begin
            case (sfr_addr)
                `GIO_SFR_P1_DATA: p1_data_d = sfr_wdata;
                `GIO_SFR_P1_DIR:  p1_dir_d  = sfr_wdata;
                `GIO_SFR_P2_DATA: p2_data_d = sfr_wdata;
                `GIO_SFR_P2_DIR:  p2_dir_d  = sfr_wdata;
                default:          ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                `GIO_SFR_P1_DATA: sfr_rdata_d = rd_all[7:0];
                `GIO_SFR_P1_DIR:  sfr_rdata_d = p1_dir_q;
                `GIO_SFR_P2_DATA: sfr_rdata_d = rd_all[15:8];
                `GIO_SFR_P2_DIR:  sfr_rdata_d = p2_dir_q;
                default:          sfr_rdata_d = 8'h00;
            endcase
        end
        if (cfg_wr && cfg_hit) begin
            rsel_d[{cfg_idx[2:0], 1'b0}] = cfg_wdata[`GIO_RSEL_LO_POS +: 3];
            rsel_d[{cfg_idx[2:0], 1'b1}] = cfg_wdata[`GIO_RSEL_HI_POS +: 3];
        end
        if (cfg_rd) begin
            cfg_rdata_d = cfg_hit ? {1'b0, rsel_q[{cfg_idx[2:0], 1'b1}], 1'b0,
                                     rsel_q[{cfg_idx[2:0], 1'b0}]} : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p1_data_q   <= `GIO_DATA_RST;
            p2_data_q   <= `GIO_DATA_RST;
            p1_dir_q    <= `GIO_DIR_RST;
            p2_dir_q    <= `GIO_DIR_RST;
            for (int k = 0; k < `GIO_NUM_RSEL; k++) begin
                rsel_q[k] <= `GIO_RSEL_RST;
            end
            sfr_rdata_q <= 8'h00;
            cfg_rdata_q <= 8'h00;
        end else begin
            p1_data_q   <= p1_data_d;
            p2_data_q   <= p2_data_d;
            p1_dir_q    <= p1_dir_d;
            p2_dir_q    <= p2_dir_d;
            rsel_q      <= rsel_d;
            sfr_rdata_q <= sfr_rdata_d;
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // pad muxing; segment use outranks every other function
    always_comb begin
        pin_out_d = data_all;
        pin_oe_d  = dir_all;
        if (dir_all[`GIO_PIN_EPULSE] && energy_pulse_enable) begin
            pin_out_d[`GIO_PIN_EPULSE] = ce_energy_pulse;
        end
        if (dir_all[`GIO_PIN_RPULSE] && reactive_pulse_enable) begin
            pin_out_d[`GIO_PIN_RPULSE] = ce_reactive_pulse;
        end
        if (eeprom_select) begin
            pin_out_d[`GIO_PIN_EE_CLK]  = ee_clk_out;
            pin_oe_d[`GIO_PIN_EE_CLK]   = ee_clk_oe;
            pin_out_d[`GIO_PIN_EE_DATA] = ee_data_out;
            pin_oe_d[`GIO_PIN_EE_DATA]  = ee_data_oe;
        end
        if (optical_uart_use) begin
            pin_out_d[`GIO_PIN_UART_TX] = optical_uart_tx;
            pin_oe_d[`GIO_PIN_UART_TX]  = 1'b1;
            pin_oe_d[`GIO_PIN_UART_RX]  = 1'b0;
        end
        pin_out_d = pin_out_d & ~seg_now;
        pin_oe_d  = pin_oe_d & ~seg_now;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out                 <= 16'h0000;
            pin_oe                  <= 16'h0000;
            pin_seg_q               <= 16'h0000;
            pin_prev_q              <= 16'h0000;
            ee_data_in_q            <= 1'b0;
            optical_uart_rx_q       <= 1'b0;
            counter0_clock_in_q     <= 1'b0;
            counter1_clock_in_q     <= 1'b0;
            high_priority_ext_irq_q <= 1'b0;
            low_priority_ext_irq_q  <= 1'b0;
        end else begin
            pin_out                 <= pin_out_d;
            pin_oe                  <= pin_oe_d;
            pin_seg_q               <= seg_now;
            pin_prev_q              <= pin_in;
            ee_data_in_q            <= pin_in[`GIO_PIN_EE_DATA];
            optical_uart_rx_q       <= pin_in[`GIO_PIN_UART_RX];
            counter0_clock_in_q     <= req_any[0];
            counter1_clock_in_q     <= req_any[1];
            high_priority_ext_irq_q <= req_any[2];
            low_priority_ext_irq_q  <= req_any[3];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_DIR_RESET: assert property ($past(sys_rst) |-> pin_oe == 16'h0000 && dir_all == 16'h0000)
        else $error("pins not inputs after reset");
    AST_DIR_OE: assert property (!$past(sys_rst) && !seg_now[3] && !$past(seg_now[3])
        |-> pin_oe[3] == $past(p1_dir_q[3]))
        else $error("pin 3 enable does not follow direction");
    AST_RSEL_WR: assert property (cfg_wr && cfg_addr == 16'h2009 |=> rsel_q[0] == $past(cfg_wdata[2:0]))
        else $error("resource select not stored");
    AST_CNT0: assert property (rsel_q[0] == 3'h2 && pin_in[0] |=> counter0_clock_in_q)
        else $error("counter0 not fed");
    AST_OR: assert property (rsel_q[0] == 3'h2 && rsel_q[2] == 3'h2 && (pin_in[0] || pin_in[2])
        |=> counter0_clock_in_q)
        else $error("shared resource not ORed");
    AST_IRQ_RISE: assert property (rsel_q[3] == 3'h4 && pin_in[3] && !pin_prev_q[3]
        |=> high_priority_ext_irq_q)
        else $error("rising edge irq missed");
    AST_IRQ_FALL: assert property (rsel_q[3] == 3'h7 && !pin_in[3] && pin_prev_q[3]
        |=> low_priority_ext_irq_q)
        else $error("falling edge irq missed");
    AST_OBSERVE: assert property (rsel_q[3] == 3'h3 && p1_dir_q[3] && pin_in[3] |=> counter1_clock_in_q)
        else $error("output pin not observed");
    AST_PULSE: assert property (p1_dir_q[6] && energy_pulse_enable && !seg_now[6]
        |=> pin_out[6] == $past(ce_energy_pulse) && pin_oe[6])
        else $error("energy pulse not routed");
    AST_EE: assert property (eeprom_select && !seg_now[5] |=> pin_oe[5] == $past(ee_data_oe))
        else $error("eeprom data enable not routed");
    AST_UART: assert property (optical_uart_use |=> pin_oe[1] && !pin_oe[2])
        else $error("uart pins not taken");
    AST_SEG: assert property (seg_now[5] |=> !pin_oe[5] && pin_seg_q[5])
        else $error("segment pin still driven");
    AST_SFR_DIR: assert property (sfr_rd && sfr_addr == 8'h91 |=> sfr_rdata_q == $past(p1_dir_q))
        else $error("direction readback wrong");
    AST_DATA_RB: assert property (sfr_rd && sfr_addr == 8'h90 && !p1_dir_q[0]
        |=> sfr_rdata_q[0] == $past(pin_in[0]))
        else $error("input pin readback wrong");

    COV_IRQ:   cover property (high_priority_ext_irq_q);
    COV_PULSE: cover property (p1_dir_q[6] && energy_pulse_enable ##1 pin_out[6]);
    COV_EE:    cover property (eeprom_select ##1 pin_oe[4]);
    COV_CNT1:  cover property (counter1_clock_in_q && p1_dir_q[3]);

endmodule : gio_port

`default_nettype wire

// ==== hw/gio_params.svh ====
`ifndef GIO_PARAMS_SVH
`define GIO_PARAMS_SVH

// special-function register addresses of the two ports
`define GIO_SFR_P1_DATA   8'h90
`define GIO_SFR_P1_DIR    8'h91
`define GIO_SFR_P2_DATA   8'hA0
`define GIO_SFR_P2_DIR    8'hA1

// configuration memory holding the resource-select fields
`define GIO_CFG_RSEL_FIRST 16'h2009
`define GIO_CFG_RSEL_LAST  16'h200E
`define GIO_RSEL_LO_POS    0
`define GIO_RSEL_HI_POS    4

// reset values
`define GIO_DIR_RST   8'h00
`define GIO_DATA_RST  8'h00
`define GIO_RSEL_RST  3'h0

// pin roles
`define GIO_PIN_UART_TX   1
`define GIO_PIN_UART_RX   2
`define GIO_PIN_EE_CLK    4
`define GIO_PIN_EE_DATA   5
`define GIO_PIN_EPULSE    6
`define GIO_PIN_RPULSE    7
`define GIO_FIRST_SEG_PIN 4
`define GIO_NUM_PINS      16
`define GIO_NUM_RSEL      12

`endif

// ==== hw/gio_pkg.sv ====
package gio_pkg;

    typedef enum logic [2:0] {
        GIO_RS_NONE     = 3'h0,
        GIO_RS_RESERVED = 3'h1,
        GIO_RS_CNT0     = 3'h2,
        GIO_RS_CNT1     = 3'h3,
        GIO_RS_HI_RISE  = 3'h4,
        GIO_RS_LO_RISE  = 3'h5,
        GIO_RS_HI_FALL  = 3'h6,
        GIO_RS_LO_FALL  = 3'h7
    } gio_rsel_e;

    // request vector bit order: counter0, counter1, high irq, low irq
    typedef logic [3:0] gio_req_t;

endpackage : gio_pkg

// ==== hw/gio_res_route.sv ====
`timescale 1ns/1ps
`default_nettype none

module gio_res_route
    import gio_pkg::*;
(
    // selection and pin state
    input  wire logic [2:0] sel,
    input  wire logic       lvl,
    input  wire logic       prev,
    input  wire logic       usable,
    // resource requests
    output gio_req_t        req
);

    always_comb begin
        req = 4'h0;
        if (usable) begin
            case (gio_rsel_e'(sel))
                GIO_RS_CNT0:    req[0] = lvl;
                GIO_RS_CNT1:    req[1] = lvl;
                GIO_RS_HI_RISE: req[2] = lvl & ~prev;
                GIO_RS_LO_RISE: req[3] = lvl & ~prev;
                GIO_RS_HI_FALL: req[2] = ~lvl & prev;
                GIO_RS_LO_FALL: req[3] = ~lvl & prev;
                default:        req = 4'h0;
            endcase
        end
    end

endmodule : gio_res_route

`default_nettype wire

// ==== bench/gio_pad_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// board side of the pads: design drive where enabled, else external drivers where enabled, pull-up elsewhere
module gio_pad_model (
    // design drive
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    // external drivers
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    // pad levels back to the design
    output logic      [15:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            // the pad shows its own driven level, so routing can count output pulses
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else begin
                // released pad floats up through the load pull-up
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule : gio_pad_model

`default_nettype wire

// ==== bench/gio_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module gio_port_bench;
    import gio_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, cfg_wdata, cfg_rdata_q, q;
    logic        sfr_wr, sfr_rd, cfg_wr, cfg_rd, c0, c1;
    logic [15:0] cfg_addr, pin_in, pin_out, pin_oe, pin_seg_q, ext_en, ext_val;
    logic [4:0]  segment_pin_count;
    logic        energy_pulse_enable, reactive_pulse_enable, eeprom_select, optical_uart_use;
    logic        ce_energy_pulse, ce_reactive_pulse, ee_clk_out, ee_clk_oe, ee_data_out, ee_data_oe;
    logic        ee_data_in_q, optical_uart_tx, optical_uart_rx_q;
    logic        counter0_clock_in_q, counter1_clock_in_q, high_priority_ext_irq_q, low_priority_ext_irq_q;
    int          fails = 0, checks = 0, cyc_n = 0, hi_n = 0, lo_n = 0;

    always #10 clk = ~clk;

    gio_port DUT (.clk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q, .cfg_addr,
        .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata_q, .segment_pin_count, .energy_pulse_enable,
        .reactive_pulse_enable, .eeprom_select, .optical_uart_use, .ce_energy_pulse, .ce_reactive_pulse,
        .ee_clk_out, .ee_clk_oe, .ee_data_out, .ee_data_oe, .ee_data_in_q, .optical_uart_tx,
        .optical_uart_rx_q, .pin_in, .pin_out, .pin_oe, .pin_seg_q, .counter0_clock_in_q,
        .counter1_clock_in_q, .high_priority_ext_irq_q, .low_priority_ext_irq_q);

    gio_pad_model pads (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_in);

    // irq pulses are counted per cycle, so a stretched pulse shows as a count above one
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        hi_n  <= hi_n + int'(high_priority_ext_irq_q === 1'b1);
        lo_n  <= lo_n + int'(low_priority_ext_irq_q === 1'b1);
        if (cyc_n == 4000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checks = checks + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // one strobe cycle on either port; strobes drop a full cycle before the next request
    task automatic acc(input logic cfg, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        if (cfg) begin
            {cfg_addr, cfg_wdata, cfg_wr, cfg_rd} = {a, d, w, !w};
        end else begin
            {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a[7:0], d, w, !w};
        end
        @(negedge clk);
        q = cfg ? cfg_rdata_q : sfr_rdata_q;
        {sfr_wr, sfr_rd, cfg_wr, cfg_rd} = 4'h0;
    endtask : acc

    task automatic wr(input logic cfg, input logic [15:0] a, input logic [7:0] d);
        acc(cfg, 1'b1, a, d);
    endtask : wr

    task automatic rd(input logic cfg, input logic [15:0] a, input logic [7:0] e);
        acc(cfg, 1'b0, a, 8'h00);
        check(16'(q), 16'(e));
    endtask : rd

    initial begin
        {sfr_addr, sfr_wdata, cfg_wdata, sfr_wr, sfr_rd, cfg_wr, cfg_rd, cfg_addr} = '0;
        {segment_pin_count, energy_pulse_enable, reactive_pulse_enable, eeprom_select} = '0;
        {optical_uart_use, ce_energy_pulse, ce_reactive_pulse, ee_clk_out, ee_clk_oe} = '0;
        {ee_data_out, ee_data_oe, optical_uart_tx, ext_en, ext_val} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        check(pin_oe, 16'h0000);
        rd(1'b0, 16'h0091, 8'h00);
        rd(1'b0, 16'h00A1, 8'h00);
        ext_en  = 16'h00FF;
        ext_val = 16'h00A5;
        wr(1'b0, 16'h0091, 8'h08);
        wr(1'b0, 16'h0090, 8'h08);
        wr(1'b0, 16'h00A1, 8'h01);
        wr(1'b0, 16'h00A0, 8'h01);
        cyc(2);
        check(pin_oe, 16'h0108);
        check(pin_out & pin_oe, 16'h0108);
        rd(1'b0, 16'h0090, 8'hAD);
        rd(1'b0, 16'h00A0, 8'hFF);
        rd(1'b0, 16'h0091, 8'h08);
        rd(1'b0, 16'h00A1, 8'h01);
        rd(1'b0, 16'h0092, 8'h00);
        $display("test sfr done");
        wr(1'b1, 16'h2009, 8'h02);
        wr(1'b1, 16'h200A, 8'h02);
        rd(1'b1, 16'h2009, 8'h02);
        rd(1'b1, 16'h2008, 8'h00);
        rd(1'b1, 16'h200F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ext_val = {13'h0000, i[1], 1'b0, i[0]};
            cyc(3);
            check(16'(counter0_clock_in_q), 16'(i[0] | i[1]));
        end
        $display("test or done");
        wr(1'b1, 16'h2009, 8'h00);
        wr(1'b0, 16'h0090, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(1'b1, 16'h200A, {1'b0, c[2:0], 4'h0});
            cyc(2);
            hi_n = 0;
            lo_n = 0;
            wr(1'b0, 16'h0090, 8'h08);
            cyc(3);
            {c1, c0} = {counter1_clock_in_q, counter0_clock_in_q};
            wr(1'b0, 16'h0090, 8'h00);
            cyc(3);
            check(16'(hi_n), 16'(c == 4 || c == 6));
            check(16'(lo_n), 16'(c == 5 || c == 7));
            check(16'({c1, c0}), 16'({c == 3, c == 2}));
        end
        rd(1'b1, 16'h200A, 8'h70);
        $display("test routing done");
        wr(1'b1, 16'h200C, 8'h02);
        wr(1'b0, 16'h0091, 8'hC8);
        wr(1'b0, 16'h0090, 8'h80);
        {energy_pulse_enable, reactive_pulse_enable, ce_energy_pulse} = 3'h7;
        cyc(3);
        check(16'({pin_oe[7:6], pin_out[7:6]}), 16'h000D);
        check(16'(counter0_clock_in_q), 16'h0001);
        {ce_energy_pulse, ce_reactive_pulse} = 2'h1;
        cyc(3);
        check(16'(pin_out[7:6]), 16'h0002);
        $display("test pulse done");
        {eeprom_select, ee_clk_oe, ee_clk_out} = 3'h7;
        ext_val = 16'h0020;
        cyc(3);
        check(16'({pin_oe[5:4], pin_out[4], ee_data_in_q}), 16'h0007);
        ext_val = 16'h0000;
        cyc(3);
        check(16'(ee_data_in_q), 16'h0000);
        {ee_data_oe, ee_data_out} = 2'h3;
        cyc(3);
        check(16'({pin_oe[5], pin_out[5], ee_data_in_q}), 16'h0007);
        eeprom_select = 1'b0;
        {optical_uart_use, ext_val} = {1'b1, 16'h0004};
        cyc(3);
        check(16'({pin_oe[1], pin_out[1], optical_uart_rx_q}), 16'h0005);
        optical_uart_tx = 1'b1;
        cyc(3);
        check(16'(pin_out[1]), 16'h0001);
        $display("test share done");
        // eeprom drive is back on, so only segment ownership can hold the enables low
        {segment_pin_count, eeprom_select} = {5'h02, 1'b1};
        cyc(3);
        check(pin_seg_q, 16'h0030);
        check(16'(pin_oe[5:4]), 16'h0000);
        $display("test segment done");
        end_of_test();
    end
endmodule : gio_port_bench

`default_nettype wire
